// *** hdl/otd_classifier.sv ***
`default_nettype none
module otd_classifier #(
    parameter int ONE_G = otd_pkg::ACC_ONE_G
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Sample and thresholds
    input wire logic sample_valid,
    input wire otd_pkg::otd_sample_s sample,
    input wire otd_pkg::otd_cfg_s cfg,
    // Candidate for the latest sample
    output otd_pkg::otd_orient_e cand
);
    logic signed [31:0] xs, ys, zs;
    logic [31:0] ax, ay, az, mxy, mall, lo_thr, hi_thr;
    logic x_small, y_small, tilt_ok, over;
    otd_pkg::otd_orient_e cls;

    assign xs = {{16{sample.x[15]}}, sample.x};
    assign ys = {{16{sample.y[15]}}, sample.y};
    assign zs = {{16{sample.z[15]}}, sample.z};
    assign ax = xs[31] ? 32'(-xs) : 32'(xs);
    assign ay = ys[31] ? 32'(-ys) : 32'(ys);
    assign az = zs[31] ? 32'(-zs) : 32'(zs);
    assign mxy = (ax > ay) ? ax : ay;
    assign mall = (mxy > az) ? mxy : az;

    // Hysteresis setting is the lower band edge in 1/256 g; 0x80 gives 0.5 g / 0.867 g
    assign lo_thr = (32'(ONE_G) * {24'h0, cfg.hyst}) >> otd_pkg::HYST_FRAC_SHIFT;
    assign hi_thr = 32'(ONE_G)
        - ((lo_thr * 32'(otd_pkg::HI_SLOPE_NUM)) >> otd_pkg::HI_SLOPE_SHIFT);

    // Low limit counts are sine of the angle at 8 per g
    assign tilt_ok = (mxy * 32'(otd_pkg::LL_CNT_PER_G)) > (32'(ONE_G) * {24'h0, cfg.ll});
    // Large readings mean motion, not gravity, so they classify as nothing
    assign over = (mall * 32'(otd_pkg::LL_CNT_PER_G)) >= (32'(ONE_G) * {24'h0, cfg.hl});
    assign x_small = ax < lo_thr;
    assign y_small = ay < lo_thr;

    always_comb begin
        cls = otd_pkg::ORI_NONE;
        if (over) begin
            cls = otd_pkg::ORI_NONE;
        end else if (!tilt_ok) begin
            cls = zs[31] ? otd_pkg::ORI_FACE_DOWN : otd_pkg::ORI_FACE_UP;
        end else if (x_small && ys > $signed(hi_thr)) begin
            cls = otd_pkg::ORI_0;
        end else if (x_small && ys < -$signed(hi_thr)) begin
            cls = otd_pkg::ORI_180;
        end else if (y_small && xs > $signed(hi_thr)) begin
            cls = otd_pkg::ORI_90;
        end else if (y_small && xs < -$signed(hi_thr)) begin
            cls = otd_pkg::ORI_270;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cand <= otd_pkg::ORI_NONE;
        end else if (sample_valid) begin
            cand <= cls;
        end
    end
endmodule
`default_nettype wire

// *** hdl/otd_orientation_tilt_detector.sv ***
`default_nettype none
module otd_orientation_tilt_detector #(
    parameter int ONE_G = otd_pkg::ACC_ONE_G,
    parameter int unsigned TP_PERIOD_US [4] = '{80000, 40000, 20000, 10000}
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Avalon-MM slave
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Acceleration samples
    input wire logic sample_valid,
    input wire otd_pkg::otd_sample_s sample,
    // Result and interrupt
    output otd_pkg::otd_orient_e orientation,
    output logic irq
);
    logic [7:0] ctrl_q, timer_q;
    otd_pkg::otd_cfg_s cfg_q;
    logic [otd_pkg::EVT_W-1:0] sts_q, en_q, evt, clr;
    logic rd_done_q;
    logic wr_lo;
    logic [31:0] rd_mux;
    otd_pkg::otd_orient_e cand, reported;
    logic [8:0] pend_cnt;
    logic screen_evt, face_evt;

    otd_classifier #(
        .ONE_G(ONE_G)
    ) u_classifier (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .sample_valid(sample_valid),
        .sample(sample),
        .cfg(cfg_q),
        .cand(cand)
    );

    otd_qualifier #(
        .TP_PERIOD_US(TP_PERIOD_US)
    ) u_qualifier (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .enable(ctrl_q[otd_pkg::CTRL_EN_BIT]),
        .rate_sel(ctrl_q[otd_pkg::CTRL_RATE_LSB +: 2]),
        .timer(timer_q),
        .cand(cand),
        .reported(reported),
        .pend_cnt(pend_cnt),
        .screen_evt(screen_evt),
        .face_evt(face_evt)
    );

    // Writes finish in their first cycle; reads take one wait state for a registered answer
    assign avs_waitrequest = avs_read && !rd_done_q;
    assign wr_lo = avs_write && avs_byteenable[0];
    assign orientation = reported;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q <= otd_pkg::RST_CTRL;
            timer_q <= otd_pkg::RST_TIMER;
            cfg_q.hyst <= otd_pkg::RST_HYST;
            cfg_q.ll <= otd_pkg::RST_LL;
            cfg_q.hl <= otd_pkg::RST_HL;
        end else if (wr_lo) begin
            case (avs_address)
                otd_pkg::OFS_CTRL: ctrl_q <= avs_writedata[7:0];
                otd_pkg::OFS_TIMER: timer_q <= avs_writedata[7:0];
                otd_pkg::OFS_HYST: cfg_q.hyst <= avs_writedata[7:0];
                otd_pkg::OFS_LL: cfg_q.ll <= avs_writedata[7:0];
                otd_pkg::OFS_HL: cfg_q.hl <= avs_writedata[7:0];
                default: ;
            endcase
        end
    end

    assign evt = {face_evt, screen_evt};
    assign clr = (wr_lo && avs_address == otd_pkg::OFS_INT_CLR)
        ? avs_writedata[otd_pkg::EVT_W-1:0] : '0;

    // An event in the same cycle as its clear stays set
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sts_q <= '0;
        end else begin
            sts_q <= (sts_q & ~clr) | evt;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            en_q <= otd_pkg::RST_INT_EN;
        end else if (wr_lo && avs_address == otd_pkg::OFS_INT_EN) begin
            en_q <= avs_writedata[otd_pkg::EVT_W-1:0];
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq <= 1'b0;
        end else begin
            irq <= |(sts_q & en_q);
        end
    end

    always_comb begin
        rd_mux = 32'h0;
        case (avs_address)
            otd_pkg::OFS_CTRL: rd_mux = {24'h0, ctrl_q};
            otd_pkg::OFS_TIMER: rd_mux = {24'h0, timer_q};
            otd_pkg::OFS_HYST: rd_mux = {24'h0, cfg_q.hyst};
            otd_pkg::OFS_LL: rd_mux = {24'h0, cfg_q.ll};
            otd_pkg::OFS_HL: rd_mux = {24'h0, cfg_q.hl};
            otd_pkg::OFS_ORIENT: rd_mux = {15'h0, pend_cnt, 5'h0, reported};
            otd_pkg::OFS_INT_STS: rd_mux = {30'h0, sts_q};
            otd_pkg::OFS_INT_EN: rd_mux = {30'h0, en_q};
            default: rd_mux = 32'h0;
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_done_q <= 1'b0;
            avs_readdata <= 32'h0;
        end else begin
            rd_done_q <= avs_read && !rd_done_q;
            if (avs_read && !rd_done_q) begin
                avs_readdata <= rd_mux;
            end
        end
    end
endmodule
`default_nettype wire

// *** hdl/otd_pkg.sv ***
`default_nettype none
package otd_pkg;
    // Core clock rate, used to turn tilt-position periods into cycle counts
    localparam int CLK_MHZ = 125;

    // Default acceleration scale, counts per g, and the low-limit scale
    localparam int ACC_ONE_G = 4096;
    localparam int LL_CNT_PER_G = 8;
    // Upper band slope: hi = one_g - lo * HI_SLOPE_NUM / 2**HI_SLOPE_SHIFT
    localparam int HI_SLOPE_NUM = 17;
    localparam int HI_SLOPE_SHIFT = 6;
    localparam int HYST_FRAC_SHIFT = 8;

    // Register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_TIMER = 8'h04;
    localparam logic [7:0] OFS_HYST = 8'h08;
    localparam logic [7:0] OFS_LL = 8'h0C;
    localparam logic [7:0] OFS_HL = 8'h10;
    localparam logic [7:0] OFS_ORIENT = 8'h14;
    localparam logic [7:0] OFS_INT_STS = 8'h18;
    localparam logic [7:0] OFS_INT_CLR = 8'h1C;
    localparam logic [7:0] OFS_INT_EN = 8'h20;

    // Field positions
    localparam int CTRL_RATE_LSB = 0;
    localparam int CTRL_EN_BIT = 7;
    localparam int EVT_SCREEN = 0;
    localparam int EVT_FACE = 1;
    localparam int EVT_W = 2;
    localparam int ORIENT_PEND_LSB = 8;

    // Reset values
    localparam logic [7:0] RST_CTRL = 8'h80;
    localparam logic [7:0] RST_TIMER = 8'h00;
    localparam logic [7:0] RST_HYST = 8'h80;
    localparam logic [7:0] RST_LL = 8'h03;
    localparam logic [7:0] RST_HL = 8'h0C;
    localparam logic [EVT_W-1:0] RST_INT_EN = 2'h0;

    typedef enum logic [2:0] {
        ORI_0 = 3'b000,
        ORI_90 = 3'b001,
        ORI_180 = 3'b010,
        ORI_270 = 3'b011,
        ORI_FACE_UP = 3'b100,
        ORI_FACE_DOWN = 3'b101,
        ORI_NONE = 3'b111
    } otd_orient_e;

    typedef struct packed {
        logic signed [15:0] x;
        logic signed [15:0] y;
        logic signed [15:0] z;
    } otd_sample_s;

    typedef struct packed {
        logic [7:0] hyst;
        logic [7:0] ll;
        logic [7:0] hl;
    } otd_cfg_s;
endpackage
`default_nettype wire

// *** hdl/otd_qualifier.sv ***
`default_nettype none
module otd_qualifier #(
    parameter int unsigned TP_PERIOD_US [4] = '{80000, 40000, 20000, 10000}
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Control
    input wire logic enable,
    input wire logic [1:0] rate_sel,
    input wire logic [7:0] timer,
    input wire otd_pkg::otd_orient_e cand,
    // Result
    output otd_pkg::otd_orient_e reported,
    output logic [8:0] pend_cnt,
    output logic screen_evt,
    output logic face_evt
);
    logic [31:0] div_q, period_cyc;
    logic tick;
    otd_pkg::otd_orient_e pend_q;
    logic [8:0] nxt;

    assign period_cyc = (TP_PERIOD_US[rate_sel] * 32'(otd_pkg::CLK_MHZ) > 32'd1)
        ? TP_PERIOD_US[rate_sel] * 32'(otd_pkg::CLK_MHZ) : 32'd1;
    // Compare with >= so a shorter rate picked mid-count still ticks at once
    assign tick = enable && (div_q >= period_cyc - 32'd1);
    assign nxt = (cand == pend_q) ? pend_cnt + 9'h001 : 9'h001;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            div_q <= 32'h0;
        end else if (!enable || tick) begin
            div_q <= 32'h0;
        end else begin
            div_q <= div_q + 32'h1;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            reported <= otd_pkg::ORI_NONE;
            pend_q <= otd_pkg::ORI_NONE;
            pend_cnt <= 9'h000;
            screen_evt <= 1'b0;
            face_evt <= 1'b0;
        end else begin
            screen_evt <= 1'b0;
            face_evt <= 1'b0;
            if (!enable) begin
                pend_q <= otd_pkg::ORI_NONE;
                pend_cnt <= 9'h000;
            end else if (tick) begin
                if (cand == otd_pkg::ORI_NONE || cand == reported) begin
                    pend_q <= otd_pkg::ORI_NONE;
                    pend_cnt <= 9'h000;
                end else if (nxt >= {1'b0, timer}) begin
                    reported <= cand;
                    pend_q <= otd_pkg::ORI_NONE;
                    pend_cnt <= 9'h000;
                    screen_evt <= ~cand[2];
                    face_evt <= cand[2];
                end else begin
                    pend_q <= cand;
                    pend_cnt <= nxt;
                end
            end
        end
    end
endmodule
`default_nettype wire

// *** sim/otd_orientation_tilt_detector_props.sv ***
`default_nettype none
module otd_orientation_tilt_detector_props #(
    parameter int unsigned TP_PERIOD_US [4] = '{80000, 40000, 20000, 10000}
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Register bus
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic avs_waitrequest,
    // Result
    input wire otd_pkg::otd_orient_e orientation,
    input wire logic irq
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    // Fastest rate slot sets the least spacing, less a few cycles of slack
    localparam int unsigned GAP_MIN = TP_PERIOD_US[3] * otd_pkg::CLK_MHZ - 8;
    logic [31:0] gap_q;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            gap_q <= 32'h0;
        end else begin
            gap_q <= $changed(orientation) ? 32'h0 : gap_q + 32'h1;
        end
    end
    stay_qualified_a:
        assert property (orientation != otd_pkg::ORI_NONE |=> orientation != otd_pkg::ORI_NONE)
        else $error("orientation fell back to none");
    tick_spacing_a:
        assert property ($changed(orientation) |-> gap_q >= GAP_MIN)
        else $error("orientation changed between ticks");
    reset_idle_a:
        assert property ($rose(rst_n) |-> orientation == otd_pkg::ORI_NONE && !irq)
        else $error("outputs not idle after reset");
    read_wait_a:
        assert property ($rose(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest)
        else $error("read not answered after one wait state");
    read_once_a:
        assert property (avs_read && !avs_waitrequest |=> !avs_read || avs_waitrequest)
        else $error("read answer held longer than one cycle");
    write_nowait_a:
        assert property (avs_write |-> !avs_waitrequest)
        else $error("write stalled");
    irq_fall_a:
        assert property ($fell(irq) |-> $past(avs_write, 2))
        else $error("interrupt dropped without a register write");
    irq_rise_a:
        assert property ($rose(irq) |-> $past(avs_write, 2)
            || $past(orientation, 2) != $past(orientation, 3))
        else $error("interrupt raised without cause");
    cover property ($rose(irq));
    cover property ($changed(orientation));
    cover property (avs_read && !avs_waitrequest);
endmodule
bind otd_orientation_tilt_detector otd_orientation_tilt_detector_props #(
    .TP_PERIOD_US(TP_PERIOD_US)
) props_u (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .avs_read(avs_read),
    .avs_write(avs_write),
    .avs_waitrequest(avs_waitrequest),
    .orientation(orientation),
    .irq(irq)
);
`default_nettype wire

// *** sim/otd_orientation_tilt_detector_tb.sv ***
`default_nettype none
module otd_orientation_tilt_detector_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] ADR [10] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18,
        8'h1C, 8'h20, 8'h3C};
    localparam logic [7:0] RV [10] = '{8'h80, 8'h00, 8'h80, 8'h03, 8'h0C, 8'h07, 8'h00,
        8'h00, 8'h00, 8'h00};
    localparam logic [15:0] XS [4] = '{16'h0000, 16'h0FA0, 16'h0000, 16'hF060};
    localparam logic [15:0] YS [4] = '{16'h0FA0, 16'h0000, 16'hF060, 16'h0000};
    logic core_clk, rst_n, avs_read, avs_write, sample_valid, irq, avs_waitrequest;
    logic [7:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, rdata;
    otd_pkg::otd_sample_s accel, sample;
    otd_pkg::otd_orient_e orientation;
    int err_count = 0, checked = 0, cyc;
    always #4 core_clk = ~core_clk;
    otd_sample_src src_u (.core_clk(core_clk), .rst_n(rst_n), .accel(accel),
        .sample_valid(sample_valid), .sample(sample));
    otd_orientation_tilt_detector #(.TP_PERIOD_US('{1, 2, 1, 1})) dut_u (
        .core_clk(core_clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .sample_valid(sample_valid), .sample(sample), .orientation(orientation), .irq(irq));
    task automatic stop_test();
        $display("errors %0d checks %0d", err_count, checked);
        if (err_count == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= d;
        @(posedge core_clk);
        while (avs_waitrequest !== 1'b0 && n < 20) begin
            n++;
            @(posedge core_clk);
        end
        rdata = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (n == 20) begin
            err_count++;
            stop_test();
        end
        @(posedge core_clk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        check(rdata, exp);
    endtask
    task automatic put(input logic [15:0] x, input logic [15:0] y, input logic [15:0] z);
        accel <= {x, y, z};
    endtask
    // Settling time after the change lets the status bit and irq catch up
    task automatic reach(input otd_pkg::otd_orient_e exp, input int minc);
        cyc = 0;
        while (orientation !== exp && cyc < 2000) begin
            cyc++;
            @(posedge core_clk);
        end
        repeat (3) @(posedge core_clk);
        check(orientation, exp);
        check(cyc > minc, 1'b1);
        if (cyc == 2000) begin
            stop_test();
        end
    endtask
    task automatic hold(input otd_pkg::otd_orient_e exp);
        repeat (600) @(posedge core_clk);
        check(orientation, exp);
    endtask
    // Polls the result register until the pending count and result match
    task automatic pend_wait(input logic [31:0] exp);
        int n;
        n = 0;
        rdata = 32'h0;
        while (rdata !== exp && n < 300) begin
            n++;
            bus(1'b0, otd_pkg::OFS_ORIENT, 32'h0);
        end
        check(rdata, exp);
        if (n == 300) begin
            stop_test();
        end
    endtask
    initial begin
        core_clk = 1'b0;
        rst_n = 1'b0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_address = 8'h00;
        avs_writedata = 32'h0;
        accel = '0;
        repeat (6) @(posedge core_clk);
        rst_n <= 1'b1;
        @(posedge core_clk);
        for (int i = 0; i < 10; i++) begin
            rd(ADR[i], {24'h0, RV[i]});
        end
        bus(1'b1, 8'h20, 32'h3);
        bus(1'b1, 8'h04, 32'h2);
        put(16'h0, 16'h0, 16'h1000);
        reach(otd_pkg::ORI_FACE_UP, 120);
        check(irq, 1'b1);
        rd(8'h18, 32'h2);
        bus(1'b1, 8'h1C, 32'h2);
        rd(8'h18, 32'h0);
        check(irq, 1'b0);
        for (int i = 0; i < 4; i++) begin
            put(XS[i], YS[i], 16'h0);
            reach(otd_pkg::otd_orient_e'(i), 120);
            bus(1'b0, 8'h18, 32'h0);
            check(rdata[0], 1'b1);
            bus(1'b1, 8'h1C, 32'h3);
        end
        put(16'hF4AC, 16'h0B54, 16'h0);
        hold(otd_pkg::ORI_270);
        bus(1'b1, 8'h08, 32'h40);
        put(16'h0, 16'h0E74, 16'h0);
        hold(otd_pkg::ORI_270);
        bus(1'b1, 8'h08, 32'h80);
        reach(otd_pkg::ORI_0, 120);
        bus(1'b1, 8'h0C, 32'h8);
        put(16'h0FA0, 16'h0, 16'h0);
        reach(otd_pkg::ORI_FACE_UP, 120);
        bus(1'b1, 8'h0C, 32'h3);
        reach(otd_pkg::ORI_90, 120);
        bus(1'b1, 8'h10, 32'h7);
        put(16'h0, 16'h0FA0, 16'h0);
        hold(otd_pkg::ORI_90);
        bus(1'b1, 8'h10, 32'h0C);
        reach(otd_pkg::ORI_0, 120);
        bus(1'b1, 8'h00, 32'h81);
        put(16'h0FA0, 16'h0, 16'h0);
        reach(otd_pkg::ORI_90, 245);
        put(16'h0, 16'h0FA0, 16'h0);
        pend_wait(32'h101);
        // A restart needs two more ticks; a carried count would report after one
        put(16'h0, 16'hF060, 16'h0);
        reach(otd_pkg::ORI_180, 300);
        bus(1'b1, 8'h00, 32'h01);
        put(16'hF060, 16'h0, 16'h0);
        hold(otd_pkg::ORI_180);
        bus(1'b1, 8'h00, 32'h80);
        reach(otd_pkg::ORI_270, 120);
        stop_test();
    end
endmodule
`default_nettype wire

// *** sim/otd_sample_src.sv ***
`default_nettype none
module otd_sample_src #(
    parameter int GAP = 8
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Acceleration chosen by the bench
    input wire otd_pkg::otd_sample_s accel,
    // Sample stream toward the block
    output logic sample_valid,
    output otd_pkg::otd_sample_s sample
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] cnt_q;
    // Between pulses the bus carries the inverse, so a stray capture shows up
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= 8'h00;
            sample_valid <= 1'b0;
            sample <= '0;
        end else begin
            cnt_q <= (cnt_q == 8'(GAP - 1)) ? 8'h00 : cnt_q + 8'h01;
            sample_valid <= (cnt_q == 8'h00);
            sample <= (cnt_q == 8'h00) ? accel : ~accel;
        end
    end
endmodule
`default_nettype wire
